/* tmrps_core_model.sv */
// Core model: drives file bus, config loads, pin and watchdog tick.
// Assumes callers resume 1 ns after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module tmrps_core_model
  import tmrps_pkg::*;
(
  input  wire logic              core_clk_in,
  input  wire logic [CNT_W-1:0]  file_rdata_in,
  output logic                   file_wr_out,
  output logic                   file_rd_out,
  output logic [ADDR_W-1:0]      file_addr_out,
  output logic [CNT_W-1:0]       file_wdata_out,
  output logic                   config_wr_out,
  output logic [CFG_W-1:0]       config_wdata_out,
  output logic                   pin_out,
  output logic                   tick_out
);
  logic [CNT_W-1:0] rq[$];
  initial begin
    {file_wr_out, file_rd_out, config_wr_out, pin_out, tick_out} = 5'h00;
    file_addr_out = 5'h00;
    file_wdata_out = 8'h00;
    config_wdata_out = 6'h00;
  end
  task automatic step(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask : step
  task automatic wr(input logic [CNT_W-1:0] d);
    file_addr_out = TIMER_COUNT_ADDR;
    file_wdata_out = d;
    file_wr_out = 1'b1;
    step(1);
    file_wr_out = 1'b0;
    // Released data must not look valid
    file_wdata_out = ~d;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input int n);
    file_addr_out = a;
    file_rd_out = 1'b1;
    repeat (n) begin
      step(1);
      rq.push_back(file_rdata_in);
    end
    file_rd_out = 1'b0;
  endtask : rd
  task automatic cfg(input logic [CFG_W-1:0] v);
    config_wdata_out = v;
    config_wr_out = 1'b1;
    step(1);
    config_wr_out = 1'b0;
    step(2);
  endtask : cfg
  task automatic tick();
    tick_out = 1'b1;
    step(1);
    tick_out = 1'b0;
    step(1);
  endtask : tick
endmodule : tmrps_core_model
`default_nettype wire

/* tmrps_edge_sync.sv */
// Edge detector for the external count pin.
// Assumes the pin is asynchronous to core_clk_in.
`default_nettype none
`timescale 1ns/1ps

module tmrps_edge_sync
  import tmrps_pkg::*;
(
  input  wire logic core_clk_in,
  input  wire logic sys_rst_in,
  input  wire logic pin_in,
  input  wire logic falling_in,
  output logic      edge_out
);

  logic meta_q;
  logic sync_q;
  logic last_q;

  // First stage feeds only the second
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= pin_in; // RULE13
      sync_q <= meta_q; // RULE13
      last_q <= sync_q;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      edge_out <= 1'b0;
    end else if (falling_in) begin
      edge_out <= last_q & ~sync_q; // RULE5
    end else begin
      edge_out <= ~last_q & sync_q; // RULE5
    end
  end

endmodule : tmrps_edge_sync

`default_nettype wire

/* tmrps_pkg.sv */
// Constants, types and the config field layout for the timer block.
// Assumes one clock, the instruction-cycle clock, and a synchronous high reset.
//
// What this block does
// RULE1: Eight-bit count register, read and written by the core as a data file.
// RULE2: Source select zero counts every instruction cycle, undivided without prescaler.
// RULE3: A count write holds counting for the next two cycles, then resumes.
// RULE4: Source select one counts edges of the external count pin.
// RULE5: Edge select zero counts rising pin edges, one counts falling edges.
// RULE6: Prescaler serves either the counter or the watchdog, never both.
// RULE7: Assignment bit zero gives prescaler to counter, one to watchdog.
// RULE8: Prescaler count has no read or write path for software.
// RULE9: Counter prescale ratios run in powers of two, 1:2 to 1:256.
// RULE10: Every reset sets all six configuration bits to one.
// RULE11: With prescaler on the counter, a count write clears the prescaler.
// RULE12: Any reset clears the prescaler count to zero.
// RULE13: External pin is sampled twice per cycle path before it advances anything.
// RULE14: Assignment and ratio bits occupy the low four configuration bits.
// RULE15: Counter ratio is two to the power of field plus one.
// RULE16: Count wraps from maximum to zero and keeps counting.
`default_nettype none

package tmrps_pkg;

  localparam int unsigned CNT_W       = 8;
  localparam int unsigned PSC_W       = 8;
  localparam int unsigned ADDR_W      = 5;
  localparam int unsigned CFG_W       = 6;
  localparam int unsigned RATIO_W     = 3;

  localparam logic [ADDR_W-1:0] TIMER_COUNT_ADDR = 5'h01;
  localparam logic [CFG_W-1:0]  TIMER_CONFIG_RST = 6'h3f; // RULE10
  localparam logic [CNT_W-1:0]  TIMER_COUNT_RST  = 8'h00;
  localparam logic [PSC_W-1:0]  PSC_RST          = 8'h00; // RULE12

  // Cycles of write hold after a count write
  localparam logic [1:0] WRITE_HOLD_CYCLES = 2'h2;

  // Field layout, low four bits hold assignment and ratio
  typedef struct packed {
    logic                 clock_source_select;  // bit 5
    logic                 count_edge_select;    // bit 4
    logic                 prescaler_assignment; // bit 3
    logic [RATIO_W-1:0]   prescale_ratio;       // bits 2:0
  } tmrps_config_t; // RULE14

  // One access from the core to the data file
  typedef struct packed {
    logic                 wr;
    logic                 rd;
    logic [ADDR_W-1:0]    addr;
    logic [CNT_W-1:0]     wdata;
  } tmrps_file_req_t;

  typedef enum logic [1:0] {
    TMRPS_RUN,
    TMRPS_HOLD1,
    TMRPS_HOLD2
  } tmrps_state_t;

endpackage : tmrps_pkg

`default_nettype wire

/* tmrps_timer.sv */
// Timer/counter with shared prescaler, seen by the core as one data file.
// Assumes core_clk_in is the instruction-cycle clock and the watchdog lies outside.
`default_nettype none
`timescale 1ns/1ps

module tmrps_timer
  import tmrps_pkg::*;
#(
  parameter int unsigned CW = CNT_W,
  parameter int unsigned PW = PSC_W
)(
  input  wire logic              core_clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic              file_wr_in,
  input  wire logic              file_rd_in,
  input  wire logic [ADDR_W-1:0] file_addr_in,
  input  wire logic [CW-1:0]     file_wdata_in,
  input  wire logic              config_wr_in,
  input  wire logic [CFG_W-1:0]  config_wdata_in,
  input  wire logic              external_count_pin_in,
  input  wire logic              watchdog_tick_in,
  input  wire logic              watchdog_clear_in,
  output logic [CW-1:0]          file_rdata_out,
  output logic                   file_rd_hit_out,
  output logic [CW-1:0]          timer_count_out,
  output logic                   timer_wrap_out,
  output logic                   watchdog_tick_out,
  output logic                   prescaler_on_watchdog_out
);

  tmrps_file_req_t req;
  tmrps_config_t   cfg_q;
  tmrps_state_t    state_q;
  logic [CW-1:0]   count_q;
  logic [PW-1:0]   psc_q;
  logic            pin_edge;
  logic            count_wr;
  logic            base_tick;
  logic            psc_tick;
  logic            psc_out;
  logic            count_tick;
  logic            wdt_psc_out;
  logic [PW-1:0]   psc_mask;
  logic [PW-1:0]   wdt_mask;

  assign req.wr    = file_wr_in;
  assign req.rd    = file_rd_in;
  assign req.addr  = file_addr_in;
  assign req.wdata = file_wdata_in;

  assign count_wr = req.wr && (req.addr == TIMER_COUNT_ADDR); // RULE1

  tmrps_edge_sync u_edge (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .pin_in      (external_count_pin_in),
    .falling_in  (cfg_q.count_edge_select),
    .edge_out    (pin_edge)
  );

  // Configuration is write-only, no read path exists
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      cfg_q <= tmrps_config_t'(TIMER_CONFIG_RST); // RULE10
    end else if (config_wr_in) begin
      cfg_q <= tmrps_config_t'(config_wdata_in);
    end
  end

  // Source of counter events before any division
  always_comb begin
    if (cfg_q.clock_source_select) begin
      base_tick = pin_edge; // RULE4
    end else begin
      base_tick = 1'b1; // RULE2
    end
  end

  // Prescaler advances on counter events or watchdog ticks, by owner
  assign psc_tick = cfg_q.prescaler_assignment ? watchdog_tick_in : base_tick; // RULE6

  // Counter ratio 2^(n+1): low n+1 bits all ones at the tick
  always_comb begin
    psc_mask = '0;
    wdt_mask = '0;
    for (int i = 0; i < PW; i++) begin
      if (i <= int'(cfg_q.prescale_ratio)) begin
        psc_mask[i] = 1'b1; // RULE15
      end
      if (i < int'(cfg_q.prescale_ratio)) begin
        wdt_mask[i] = 1'b1;
      end
    end
  end

  assign psc_out     = psc_tick && ((psc_q & psc_mask) == psc_mask); // RULE9
  assign wdt_psc_out = psc_tick && ((psc_q & wdt_mask) == wdt_mask);

  // Hidden prescaler count, no file address decodes it
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      psc_q <= PSC_RST; // RULE12
    end else if (count_wr && !cfg_q.prescaler_assignment) begin
      psc_q <= PSC_RST; // RULE11
    end else if (watchdog_clear_in && cfg_q.prescaler_assignment) begin
      psc_q <= PSC_RST;
    end else if (psc_tick) begin
      psc_q <= psc_q + PW'(1); // RULE8
    end
  end

  // Counter sees divided or undivided events by assignment bit
  assign count_tick = cfg_q.prescaler_assignment ? base_tick : psc_out; // RULE7

  // Write hold sequencing
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state_q <= TMRPS_RUN;
    end else if (count_wr) begin
      state_q <= TMRPS_HOLD1; // RULE3
    end else begin
      unique case (state_q)
        TMRPS_RUN:   state_q <= TMRPS_RUN;
        TMRPS_HOLD1: state_q <= TMRPS_HOLD2; // RULE3
        TMRPS_HOLD2: state_q <= TMRPS_RUN;
        default:     state_q <= TMRPS_RUN;
      endcase
    end
  end

  // Write wins over a count in the same cycle
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      count_q <= CW'(TIMER_COUNT_RST);
    end else if (count_wr) begin
      count_q <= req.wdata; // RULE1
    end else if (count_tick && state_q == TMRPS_RUN) begin
      count_q <= count_q + CW'(1); // RULE16
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      timer_wrap_out <= 1'b0;
    end else begin
      timer_wrap_out <= !count_wr && count_tick && state_q == TMRPS_RUN && (&count_q); // RULE16
    end
  end

  // Read data registered, one cycle after the read strobe
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      file_rdata_out  <= '0;
      file_rd_hit_out <= 1'b0;
    end else begin
      file_rd_hit_out <= req.rd && (req.addr == TIMER_COUNT_ADDR);
      file_rdata_out  <= (req.rd && req.addr == TIMER_COUNT_ADDR) ? count_q : '0; // RULE1
    end
  end

  // Watchdog gets prescaled ticks only while it owns the prescaler
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      watchdog_tick_out         <= 1'b0;
      prescaler_on_watchdog_out <= 1'b1;
      timer_count_out           <= '0;
    end else begin
      watchdog_tick_out         <= cfg_q.prescaler_assignment ? wdt_psc_out
                                                              : watchdog_tick_in; // RULE6
      prescaler_on_watchdog_out <= cfg_q.prescaler_assignment; // RULE7
      timer_count_out           <= count_q;
    end
  end

endmodule : tmrps_timer

`default_nettype wire

/* tmrps_timer_assertions.sv */
// Port checker for the timer block.
// Assumes it is bound onto tmrps_timer, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module tmrps_timer_assertions
  import tmrps_pkg::*;
#(parameter int unsigned CW = CNT_W)(
  input wire logic              core_clk_in,
  input wire logic              sys_rst_in,
  input wire logic              file_wr_in,
  input wire logic              file_rd_in,
  input wire logic [ADDR_W-1:0] file_addr_in,
  input wire logic [CW-1:0]     file_wdata_in,
  input wire logic              config_wr_in,
  input wire logic [CFG_W-1:0]  config_wdata_in,
  input wire logic              watchdog_tick_in,
  input wire logic [CW-1:0]     file_rdata_out,
  input wire logic              file_rd_hit_out,
  input wire logic [CW-1:0]     timer_count_out,
  input wire logic              timer_wrap_out,
  input wire logic              watchdog_tick_out,
  input wire logic              prescaler_on_watchdog_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  logic [CFG_W-1:0] cfg_q;
  logic [2:0]       quiet_q;
  logic             hit;
  assign hit = file_addr_in == TIMER_COUNT_ADDR;
  // Shadow of the write-only config
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) cfg_q <= 6'h3f;
    else if (config_wr_in) cfg_q <= config_wdata_in;
  end
  // Margin past hold and config latency
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in || config_wr_in || (file_wr_in && hit)) quiet_q <= 3'h0;
    else if (quiet_q != 3'h4) quiet_q <= quiet_q + 3'h1;
  end
  rd_hit_a: assert property (file_rd_in && hit && !file_wr_in |=>
    file_rd_hit_out && file_rdata_out == timer_count_out) else $error("read hit wrong");
  rd_miss_a: assert property (file_rd_in && !hit |=>
    !file_rd_hit_out && file_rdata_out == 8'h00) else $error("unmapped read answered");
  wr_load_a: assert property (file_wr_in && hit ##1 !(file_wr_in && hit) |=>
    timer_count_out == $past(file_wdata_in, 2)) else $error("write not loaded");
  wr_hold_a: assert property (file_wr_in && hit ##1 !(file_wr_in && hit) [*2] |=>
    $stable(timer_count_out)) else $error("count moved in hold");
  tmr_inc_a: assert property (!cfg_q[5] && cfg_q[3] && quiet_q == 3'h4 |=>
    timer_count_out == $past(timer_count_out) + 8'h01) else $error("no increment");
  wrap_zero_a: assert property (timer_wrap_out |=> timer_count_out == 8'h00)
    else $error("wrap without zero");
  psa_out_a: assert property (!config_wr_in && !$past(config_wr_in) |->
    prescaler_on_watchdog_out == cfg_q[3]) else $error("assignment wrong");
  wdt_pass_a: assert property (watchdog_tick_in && !cfg_q[3] && quiet_q != 3'h0 |=>
    watchdog_tick_out) else $error("watchdog tick divided");
  rst_val_a: assert property (disable iff (1'b0) sys_rst_in |=>
    prescaler_on_watchdog_out && !timer_wrap_out) else $error("reset values wrong");
endmodule : tmrps_timer_assertions
bind tmrps_timer tmrps_timer_assertions #(.CW(CW)) chk_u (.*);
`default_nettype wire

/* tmrps_timer_tb.sv */
// Self-checking bench for the timer block.
// Assumes the core model drives every bus, pin and tick input.
`timescale 1ns/1ps
`default_nettype none
module tmrps_timer_tb
  import tmrps_pkg::*;
;
  logic              clk, rst, wr, rd, cw, pin, tk, wdo, pow, wcl, hit, wrp;
  logic [ADDR_W-1:0] addr;
  logic [CNT_W-1:0]  wd, rdo, a, tco;
  logic [CFG_W-1:0]  cd;
  int                fails, check_count, cyc, wdn, wrn;
  logic [CNT_W-1:0]  ex[5] = '{8'hfe, 8'hfe, 8'hfe, 8'hff, 8'h00};
  tmrps_timer dut_u (.core_clk_in(clk), .sys_rst_in(rst), .file_wr_in(wr), .file_rd_in(rd),
    .file_addr_in(addr), .file_wdata_in(wd), .config_wr_in(cw), .config_wdata_in(cd),
    .external_count_pin_in(pin), .watchdog_tick_in(tk), .watchdog_clear_in(wcl),
    .file_rdata_out(rdo), .file_rd_hit_out(hit), .timer_count_out(tco), .timer_wrap_out(wrp),
    .watchdog_tick_out(wdo), .prescaler_on_watchdog_out(pow));
  tmrps_core_model core_u (.core_clk_in(clk), .file_rdata_in(rdo),
    .file_wr_out(wr), .file_rd_out(rd), .file_addr_out(addr), .file_wdata_out(wd),
    .config_wr_out(cw), .config_wdata_out(cd), .pin_out(pin), .tick_out(tk));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (!rst && wdo) wdn++;
    if (!rst && wrp) wrn++;
    // Whole run is about 2100 cycles
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end
  task automatic chk(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd1(input logic [CNT_W-1:0] exp);
    core_u.rd(TIMER_COUNT_ADDR, 1);
    chk(core_u.rq.pop_front(), exp);
    chk({7'h00, hit}, 8'h01);
  endtask : rd1
  task automatic results();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  initial begin
    rst = 1'b1;
    wcl = 1'b0;
    core_u.step(12);
    rst = 1'b0;
    chk({7'h00, pow}, 8'h01);
    core_u.cfg(6'h0f);
    core_u.wr(8'hfe);
    core_u.rd(TIMER_COUNT_ADDR, 5);
    foreach (ex[i]) chk(core_u.rq.pop_front(), ex[i]);
    chk(tco, 8'h00);
    chk(wrn[7:0], 8'h01);
    core_u.rd(5'h02, 1);
    chk(core_u.rq.pop_front(), 8'h00);
    chk({7'h00, hit}, 8'h00);
    for (int r = 0; r < 8; r++) begin
      core_u.cfg({3'h0, r[2:0]});
      core_u.rd(TIMER_COUNT_ADDR, 1);
      a = core_u.rq.pop_front();
      core_u.step((6 << r) - 1);
      rd1(a + 8'h03);
    end
    core_u.wr(8'h40);
    core_u.step(150);
    core_u.wr(8'h40);
    core_u.step(200);
    rd1(8'h40);
    core_u.step(100);
    rd1(8'h41);
    for (int e = 0; e < 2; e++) begin
      core_u.cfg({1'b1, e[0], 4'h8});
      core_u.wr(8'h00);
      core_u.step(3);
      core_u.pin_out = 1'b1;
      core_u.step(6);
      rd1(e ? 8'h00 : 8'h01);
      core_u.pin_out = 1'b0;
      core_u.step(6);
      rd1(8'h01);
    end
    core_u.cfg(6'h09);
    wcl = 1'b1;
    core_u.step(1);
    wcl = 1'b0;
    wdn = 0;
    core_u.tick();
    chk(wdn[7:0], 8'h00);
    wdn = 0;
    repeat (4) core_u.tick();
    core_u.step(3);
    chk(wdn[7:0], 8'h02);
    core_u.cfg(6'h01);
    wdn = 0;
    repeat (3) core_u.tick();
    core_u.step(3);
    chk(wdn[7:0], 8'h03);
    rst = 1'b1;
    core_u.step(2);
    rst = 1'b0;
    chk({7'h00, pow}, 8'h01);
    results();
  end
endmodule : tmrps_timer_tb
`default_nettype wire
